/* File: rtl/adcc_defs.vh */
// Constants for the converter control block: register offsets, bit fields, reset values
// and timing counts.
// Assumes inclusion by bare name from the design and testbench files of this block.
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH

// Register byte offsets on the APB slave.
`define ADCC_OFF_CTRL 8'hC0
`define ADCC_OFF_P0DIS 8'hC4
`define ADCC_OFF_RESULT 8'hC8
`define ADCC_OFF_IRQCFG 8'hCC
`define ADCC_OFF_STATUS 8'hD0
`define ADCC_OFF_MASK 8'hD4
`define ADCC_OFF_P0READ 8'hD8

// Field positions in the converter control register.
`define ADCC_CTRL_ENABLE 7
`define ADCC_CTRL_DONE 4
`define ADCC_CTRL_START 3
`define ADCC_CTRL_RCSEL 2
`define ADCC_CTRL_CHHI 1
`define ADCC_CTRL_CHLO 0

// Field positions in the interrupt configuration register.
`define ADCC_CFG_GLOBAL 0
`define ADCC_CFG_CONV 1
`define ADCC_CFG_STDTIME 2

// Reset values.
`define ADCC_RST_CTRL 8'h00
`define ADCC_RST_P0DIS 8'h00
`define ADCC_RST_RESULT 8'h00

// Oscillator periods per machine cycle, normal and standard timing.
`define ADCC_MC_FAST 6
`define ADCC_MC_STD 12

// Machine cycles from start to completion of one conversion.
`define ADCC_CONV_MC 31

// Result width.
`define ADCC_RES_W 8

`endif

/* File: rtl/adcc_sar.v */
// Successive approximation sequencer: counts conversion steps and resolves eight bits.
// Assumes a one-cycle start pulse, one-cycle step ticks and a comparator already
// synchronised to pclk (high when the input is above the trial level).
`timescale 1ns/1ns
`include "adcc_defs.vh"

module adcc_sar #(
  parameter STEPS = `ADCC_CONV_MC,
  parameter RES_W = `ADCC_RES_W
) (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire step,
  input wire comp_above,
  output reg [RES_W-1:0] trial_code,
  output reg busy,
  output reg finish,
  output reg [RES_W-1:0] result
);

  // Step counter, wide enough for the whole conversion.
  reg [5:0] cnt_r;
  // Index of the first step at which a bit is decided.
  localparam [5:0] FIRST_BIT = STEPS[5:0] - RES_W[5:0];
  // Index of the step that ends the conversion.
  localparam [5:0] LAST_STEP = STEPS[5:0] - 6'h01;
  // Bit under trial, counted from the MSB.
  wire [5:0] bit_pos = cnt_r - FIRST_BIT;
  wire [2:0] bit_idx = 3'h7 - bit_pos[2:0];

  // Walks the trial code from the MSB down; the last step ends the conversion.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 6'h00;
      busy <= 1'b0;
      finish <= 1'b0;
      trial_code <= {RES_W{1'b0}};
      result <= {RES_W{1'b0}};
    end else begin
      finish <= 1'b0;
      if (start && !busy) begin
        // A fresh conversion begins with only the MSB set on trial.
        busy <= 1'b1;
        cnt_r <= 6'h00;
        trial_code <= {1'b1, {(RES_W-1){1'b0}}};
      end else if (busy && step) begin
        cnt_r <= cnt_r + 6'h01;
        if (cnt_r >= FIRST_BIT) begin
          // Keep or drop the bit under trial, then try the next lower one.
          if (!comp_above) begin
            trial_code[bit_idx] <= 1'b0;
          end
          if (bit_idx != 3'h0) begin
            trial_code[bit_idx - 3'h1] <= 1'b1;
          end
        end
        if (cnt_r == LAST_STEP) begin
          // Completion: the resolved code is the result.
          busy <= 1'b0;
          finish <= 1'b1;
          result <= comp_above ? trial_code : {trial_code[RES_W-1:1], 1'b0};
        end
      end
    end
  end

endmodule // adcc_sar

/* File: rtl/adcc_top.v */
// Converter control block: APB registers, start and done handshake, channel lock,
// result holding, interrupt request and port 0 digital input disable.
// Assumes one clock pclk at 10 MHz, the analog front end outside, and an APB master.
//
// Contract
// - Machine cycle is 6 or 12 oscillator periods.
// - Each input-disable bit turns off one pin.
// - Disabled port 0 bits read as zero.
// - Four-way multiplexer, 8-bit successive approximation.
// - Channel select locked during conversion.
// - Writing start begins; start reads one throughout.
// - Completion clears start, sets done together.
// - Interrupt needs done, both enables, priority; irq uses only stat_r and mask_r.
// - Result loaded on completion, held until restart.
// - Only software clears done; done blocks start.
// - Start write loads channel; done clear doesn't.
// - Enable cannot clear while start or done.
// - Ideal result is Vin times 256 over span.
// - CPU-clocked conversion takes 31 machine cycles.
// - RC select switches to the RC oscillator.
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`include "adcc_defs.vh"

module adcc_top #(
  parameter MC_FAST = `ADCC_MC_FAST,
  parameter MC_STD = `ADCC_MC_STD
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] port0_pins,
  input wire comp_above,
  input wire rc_osc,
  input wire prio_win,
  output reg [7:0] port0_din_en,
  output reg [1:0] mux_sel,
  output reg [7:0] dac_code,
  output reg conv_power,
  output reg conv_irq_req,
  output reg irq
);

  // Control register fields.
  reg enable_r;
  reg done_r;
  reg start_r;
  reg rcsel_r;
  reg [1:0] chan_r;
  // Port 0 input-disable register.
  reg [7:0] p0dis_r;
  // Held conversion result.
  reg [7:0] result_r;
  // Interrupt configuration: global enable, converter enable, standard timing.
  reg glob_en_r;
  reg conv_en_r;
  reg stdtime_r;
  // Sticky event status and its mask.
  reg stat_r;
  reg mask_r;

  // Three-stage synchronisers for pins from outside the clock domain.
  reg [7:0] p0_s1;
  reg [7:0] p0_s2;
  reg [7:0] p0_s3;
  reg [7:0] p0_stable;
  reg [2:0] cmp_s;
  reg cmp_stable;
  reg [2:0] rc_s;
  reg rc_stable;
  reg rc_prev;

  // Machine cycle divider.
  reg [3:0] div_r;
  reg mc_tick;

  // Sequencer handshake.
  wire sar_finish;
  wire [7:0] sar_trial;
  wire [7:0] sar_result;
  reg sar_start;

  // Picks the changed value only when the second and third stages agree.
  function agree;
    input s2;
    input s3;
    input old;
    begin
      agree = (s2 == s3) ? s3 : old;
    end
  endfunction

  // Bus strobes: setup latches the answer, access with pready completes.
  wire setup = psel && !penable;
  wire done_xfer = psel && penable && pready;
  wire wr_xfer = done_xfer && pwrite;
  wire rd_xfer = done_xfer && !pwrite;

  // Synchronises the port pins, comparator and RC oscillator.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0_s1 <= 8'h00;
      p0_s2 <= 8'h00;
      p0_s3 <= 8'h00;
      p0_stable <= 8'h00;
      cmp_s <= 3'h0;
      cmp_stable <= 1'b0;
      rc_s <= 3'h0;
      rc_stable <= 1'b0;
      rc_prev <= 1'b0;
    end else begin
      p0_s1 <= port0_pins;
      p0_s2 <= p0_s1;
      p0_s3 <= p0_s2;
      // Per bit, a change counts once stages two and three agree.
      p0_stable <= (~(p0_s2 ^ p0_s3) & p0_s3) | ((p0_s2 ^ p0_s3) & p0_stable);
      cmp_s <= {cmp_s[1:0], comp_above};
      cmp_stable <= agree(cmp_s[1], cmp_s[2], cmp_stable);
      rc_s <= {rc_s[1:0], rc_osc};
      rc_stable <= agree(rc_s[1], rc_s[2], rc_stable);
      rc_prev <= rc_stable;
    end
  end
  // Agreed comparator level without the holding stage, so a step sees its trial in time.
  wire cmp_now = agree(cmp_s[1], cmp_s[2], cmp_stable);

  // Divides pclk into machine cycle ticks of 6 or 12 periods.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 4'h0;
      mc_tick <= 1'b0;
    end else begin
      if (div_r >= (stdtime_r ? MC_STD[3:0] : MC_FAST[3:0]) - 4'h1) begin
        div_r <= 4'h0;
        mc_tick <= 1'b1;
      end else begin
        div_r <= div_r + 4'h1;
        mc_tick <= 1'b0;
      end
    end
  end

  // Step source: machine cycles, or rising edges of the RC oscillator.
  wire step = rcsel_r ? (rc_stable && !rc_prev) : mc_tick;

  // Control register write decode.
  wire ctrl_wr = wr_xfer && (paddr == `ADCC_OFF_CTRL);
  wire wr_start = pwdata[`ADCC_CTRL_START];
  wire wr_done = pwdata[`ADCC_CTRL_DONE];
  wire wr_enable = pwdata[`ADCC_CTRL_ENABLE];
  // Idle means neither busy nor waiting for done to be cleared.
  wire idle = !start_r && !done_r;
  wire take_start = ctrl_wr && wr_start && idle && (enable_r || wr_enable);

  // Control register: software writes and hardware completion.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= 1'b0;
      done_r <= 1'b0;
      start_r <= 1'b0;
      rcsel_r <= 1'b0;
      chan_r <= 2'h0;
      sar_start <= 1'b0;
    end else begin
      sar_start <= take_start;
      if (ctrl_wr) begin
        // Enable may only fall when neither start nor done is set.
        if (wr_enable || idle) begin
          enable_r <= wr_enable;
        end
        // Channel and clock source change only when idle, never while done.
        if (idle) begin
          chan_r <= pwdata[1:0];
          rcsel_r <= pwdata[`ADCC_CTRL_RCSEL];
        end
      end
      if (take_start) begin
        start_r <= 1'b1;
      end else if (sar_finish) begin
        start_r <= 1'b0;
      end
      // Completion sets done and wins over a same-cycle software clear.
      if (sar_finish) begin
        done_r <= 1'b1;
      end else if (ctrl_wr && !wr_done) begin
        done_r <= 1'b0;
      end
    end
  end

  // Result register loads only at completion and holds otherwise.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= `ADCC_RST_RESULT;
    end else if (sar_finish) begin
      result_r <= sar_result;
    end
  end

  // Remaining software registers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0dis_r <= `ADCC_RST_P0DIS;
      glob_en_r <= 1'b0;
      conv_en_r <= 1'b0;
      stdtime_r <= 1'b0;
      mask_r <= 1'b0;
    end else if (wr_xfer) begin
      case (paddr)
        `ADCC_OFF_P0DIS: begin
          p0dis_r <= pwdata[7:0];
        end
        `ADCC_OFF_IRQCFG: begin
          glob_en_r <= pwdata[`ADCC_CFG_GLOBAL];
          conv_en_r <= pwdata[`ADCC_CFG_CONV];
          stdtime_r <= pwdata[`ADCC_CFG_STDTIME];
        end
        `ADCC_OFF_MASK: begin
          mask_r <= pwdata[0];
        end
        default: begin
          mask_r <= mask_r;
        end
      endcase
    end
  end

  // Sticky completion status, cleared by reading it; a new event wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= 1'b0;
    end else if (sar_finish) begin
      stat_r <= 1'b1;
    end else if (rd_xfer && paddr == `ADCC_OFF_STATUS) begin
      stat_r <= 1'b0;
    end
  end

  // Read data mux, used at the setup phase.
  reg [31:0] rd_mux;
  reg rd_bad;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_bad = 1'b0;
    case (paddr)
      `ADCC_OFF_CTRL: begin
        rd_mux[7:0] = {enable_r, 2'b00, done_r, start_r, rcsel_r, chan_r};
      end
      `ADCC_OFF_P0DIS: begin
        rd_mux[7:0] = p0dis_r;
      end
      `ADCC_OFF_RESULT: begin
        rd_mux[7:0] = result_r;
      end
      `ADCC_OFF_IRQCFG: begin
        rd_mux[2:0] = {stdtime_r, conv_en_r, glob_en_r};
      end
      `ADCC_OFF_STATUS: begin
        rd_mux[0] = stat_r;
      end
      `ADCC_OFF_MASK: begin
        rd_mux[0] = mask_r;
      end
      `ADCC_OFF_P0READ: begin
        rd_mux[7:0] = p0_stable & ~p0dis_r;
      end
      default: begin
        rd_bad = 1'b1;
      end
    endcase
  end

  // APB answer: registered in setup, so every access phase lasts one cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pready <= 1'b1;
      pslverr <= rd_bad;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Registered outputs to the analog front end and interrupt system.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_din_en <= 8'hFF;
      mux_sel <= 2'h0;
      dac_code <= 8'h00;
      conv_power <= 1'b0;
      conv_irq_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      port0_din_en <= ~p0dis_r;
      mux_sel <= chan_r;
      dac_code <= sar_trial;
      conv_power <= enable_r;
      conv_irq_req <= done_r && glob_en_r && conv_en_r && prio_win;
      irq <= stat_r && mask_r;
    end
  end

  // Successive approximation sequencer.
  adcc_sar #(
    .STEPS(`ADCC_CONV_MC),
    .RES_W(`ADCC_RES_W)
  ) u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .start(sar_start),
    .step(step),
    .comp_above(cmp_now),
    .trial_code(sar_trial),
    .busy(),
    .finish(sar_finish),
    .result(sar_result)
  );

endmodule // adcc_top

/* File: testbench/adcc_top_asserts.sv */
// Checker for the converter control block, seeing only its top-level ports.
// Assumes one clock pclk, asynchronous active-low presetn, and the register map header.
`timescale 1ns/1ns
`include "adcc_defs.vh"

module adcc_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire prio_win,
  input wire [7:0] port0_din_en,
  input wire [1:0] mux_sel,
  input wire conv_power,
  input wire conv_irq_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed transfer, and whether its address is one of the seven mapped words.
  wire acc = psel && penable && pready;
  wire mapped = (paddr >= `ADCC_OFF_CTRL) && (paddr <= `ADCC_OFF_P0READ) && (paddr[1:0] == 2'h0);
  // Completed writes and reads of single registers.
  wire ctrl_wr = acc && pwrite && (paddr == `ADCC_OFF_CTRL);
  wire p0dis_wr = acc && pwrite && (paddr == `ADCC_OFF_P0DIS);
  wire p0_rd = acc && !pwrite && (paddr == `ADCC_OFF_P0READ);
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready not one cycle after setup");
  property p_idle; !psel |-> !pready; endproperty
  a_idle: assert property (p_idle) else $error("pready while not selected");
  property p_err; pready |-> (pslverr == !mapped); endproperty
  a_err: assert property (p_err) else $error("pslverr does not match address map");
  property p_din; p0dis_wr |-> ##2 port0_din_en == ~$past(pwdata[7:0], 2); endproperty
  a_din: assert property (p_din) else $error("input disable not applied");
  property p_rd0; p0_rd |-> (prdata[7:0] & ~port0_din_en) == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("disabled port bit read as one");
  property p_mux; $changed(mux_sel) |-> $past(ctrl_wr, 2); endproperty
  a_mux: assert property (p_mux) else $error("channel changed without a control write");
  property p_irq; conv_irq_req |-> $past(prio_win); endproperty
  a_irq: assert property (p_irq) else $error("request without priority win");
  property p_pwr; conv_irq_req |-> conv_power; endproperty
  a_pwr: assert property (p_pwr) else $error("converter off while done");
endmodule // adcc_chk

bind adcc_top adcc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .prio_win(prio_win), .port0_din_en(port0_din_en), .mux_sel(mux_sel),
  .conv_power(conv_power), .conv_irq_req(conv_irq_req));

/* File: testbench/tb.sv */
// Self-checking bench for the converter control block over APB.
// Assumes the block answers each setup with one access cycle.
`timescale 1ns/1ns
`include "adcc_defs.vh"
`define CHK(g,e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %0t: got %0h exp %0h", $time, g, e); end end

module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic comp_above = 0, rc_osc = 0, prio_win = 0;
  logic [7:0] paddr = 0, port0_pins = 8'hFF, rc;
  logic [31:0] pwdata = 0, rd;
  logic err;
  wire [31:0] prdata;
  wire pready, pslverr, conv_power, conv_irq_req, irq;
  wire [7:0] port0_din_en, dac_code;
  wire [1:0] mux_sel;
  int n_errors = 0, cmp_count = 0, cyc = 0, t0, mc, i;

  adcc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port0_pins(port0_pins), .comp_above(comp_above), .rc_osc(rc_osc), .prio_win(prio_win),
    .port0_din_en(port0_din_en), .mux_sel(mux_sel), .dac_code(dac_code),
    .conv_power(conv_power), .conv_irq_req(conv_irq_req), .irq(irq));

  always #50 pclk = ~pclk;

  // Analog level of each channel sits half a step above its code, so the ideal result is exact.
  function automatic [7:0] lvl(input [1:0] c);
    lvl = {c, 6'h25};
  endfunction

  // Comparator model and a slow RC oscillator with a period of eight pclk cycles.
  always @(posedge pclk) begin
    comp_above <= (dac_code <= lvl(mux_sel));
    if (cyc % 4 == 0) rc_osc <= ~rc_osc;
  end

  // Cycle counter; a hang counts as a mismatch and ends the run.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end

  // One APB transfer: setup, then access held until pready is sampled high.
  task automatic apb(input bit w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task test_done;
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence: reset values, port 0 disable, then one conversion per channel.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, `ADCC_OFF_CTRL, 0); `CHK(rd[7:0], 8'h00)
    `CHK(port0_din_en, 8'hFF)
    apb(0, 8'h00, 0); `CHK(err, 1'b1)
    apb(1, `ADCC_OFF_P0DIS, 32'h0F);
    repeat (6) @(posedge pclk);
    apb(0, `ADCC_OFF_P0READ, 0); `CHK(rd[7:0], 8'hF0)
    `CHK(port0_din_en, 8'hF0)
    apb(1, `ADCC_OFF_CTRL, 32'h80);
    // The converter settles for 10 us after enable before the first start.
    repeat (100) @(posedge pclk);
    for (int ch = 0; ch < 4; ch++) begin
      // Channel 2 uses standard timing, channel 3 the RC clock.
      rc = (ch == 3) ? 8'h04 : 8'h00;
      mc = (ch == 2) ? `ADCC_MC_STD : `ADCC_MC_FAST;
      apb(1, `ADCC_OFF_MASK, ch != 0);
      apb(1, `ADCC_OFF_IRQCFG, (ch == 2) ? 32'h7 : 32'h3);
      prio_win <= (ch != 1);
      apb(1, `ADCC_OFF_CTRL, 8'h88 | rc | ch);
      t0 = cyc;
      apb(0, `ADCC_OFF_CTRL, 0); `CHK(rd[7:0], 8'h88 | rc | ch)
      `CHK(mux_sel, ch[1:0])
      apb(1, `ADCC_OFF_CTRL, ~ch & 3);
      apb(0, `ADCC_OFF_CTRL, 0); `CHK(rd[7:0], 8'h88 | rc | ch)
      `CHK(conv_power, 1'b1)
      for (i = 0; i < 300 && rd[4] !== 1'b1; i++) apb(0, `ADCC_OFF_CTRL, 0);
      if (rc == 0) `CHK((cyc - t0 >= 30 * mc) && (cyc - t0 <= 31 * mc + 12), 1'b1)
      `CHK(rd[7:0], 8'h90 | rc | ch)
      apb(0, `ADCC_OFF_RESULT, 0); `CHK(rd[7:0], lvl(ch))
      `CHK(irq, ch != 0)
      `CHK(conv_irq_req, ch != 1)
      apb(1, `ADCC_OFF_CTRL, 8'h98 | rc | (~ch & 3));
      apb(0, `ADCC_OFF_CTRL, 0); `CHK(rd[7:0], 8'h90 | rc | ch)
      apb(1, `ADCC_OFF_CTRL, 8'h80 | (~ch & 3));
      apb(0, `ADCC_OFF_CTRL, 0); `CHK(rd[7:0], 8'h80 | rc | ch)
      apb(0, `ADCC_OFF_RESULT, 0); `CHK(rd[7:0], lvl(ch))
      apb(0, `ADCC_OFF_STATUS, 0); `CHK(rd[0], 1'b1)
      apb(0, `ADCC_OFF_STATUS, 0); `CHK(rd[0], 1'b0)
      `CHK(irq, 1'b0)
    end
    apb(1, `ADCC_OFF_CTRL, 0);
    apb(0, `ADCC_OFF_CTRL, 0); `CHK(rd[7:0], 8'h00)
    `CHK(conv_power, 1'b0)
    test_done;
  end
endmodule // tb
